// file: core/ptp_if.sv
`timescale 1ns/1ps
interface ptp_sync_if #(parameter int N = 5);
    logic [N-1:0] raw;
    logic [N-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : ptp_sync_if

// file: core/ptp_pkg.sv
package ptp_pkg;
    localparam int CLK_HZ = 25000000;
    // Over-current retry wait in microseconds.
    localparam int RETRY_WAIT_US = 85000;
    localparam int RETRY_WAIT_CYC = RETRY_WAIT_US * (CLK_HZ / 1000000);
    localparam int RETRY_MAX = 5;
    localparam int ATTACK_DELAY_CYC = 2500000;
    localparam int OC_WINDOW_US = 100;
    localparam int OC_WINDOW_CYC = OC_WINDOW_US * (CLK_HZ / 1000000);
    localparam int ATTEN_W = 8;
    localparam int ATTEN_STEP = 1;
    localparam logic [ATTEN_W-1:0] ATTEN_RESET = 8'h00;
    localparam int SYNC_STAGES = 3;
endpackage : ptp_pkg

// file: core/ptp_protect.sv
`timescale 1ns/1ps
module ptp_protect #(
    parameter int ATTACK_CYC = ptp_pkg::ATTACK_DELAY_CYC, // Attack delay in cycles.
    parameter int RETRY_CYC = ptp_pkg::RETRY_WAIT_CYC, // Over-current wait in cycles.
    parameter int OC_WIN_CYC = ptp_pkg::OC_WINDOW_CYC, // Retry qualification window.
    parameter int RELEASE_STEP = ptp_pkg::ATTEN_STEP // Release step in 0.5 dB units.
) (
    input wire logic clk_sys, // System clock, 25 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic clk_en, // Clock enable; freezes all state when low.
    input wire logic thermal_foldback_enable_pin, // High enables foldback.
    input wire logic temp_warn_raw, // Sensor: above warning threshold.
    input wire logic temp_err_raw, // Sensor: thermal error.
    input wire logic overcurrent_raw, // Sensor: output over-current.
    input wire logic undervoltage_raw, // Sensor: power_stage_supply low.
    output logic [ptp_pkg::ATTEN_W-1:0] atten_steps, // Attenuation in 0.5 dB steps.
    output logic power_out_en, // High: power stages drive; low: high impedance.
    output logic shutdown, // High: latched shutdown state.
    output logic thermal_warning_out_o, // Open-drain output level, always 0.
    output logic thermal_warning_out_oe, // Drive enable, high pulls low.
    output logic overcurrent_error_out_o, // Open-drain output level, always 0.
    output logic overcurrent_error_out_oe, // Drive enable, high pulls low.
    output logic undervoltage_thermal_error_out_o, // Open-drain output level, always 0.
    output logic undervoltage_thermal_error_out_oe // Drive enable, high pulls low.
);
    localparam int AW = ptp_pkg::ATTEN_W;
    localparam logic [AW-1:0] AMAX = '1;
    localparam logic [AW-1:0] ATTEN_RESET_V = ptp_pkg::ATTEN_RESET;

    ptp_sync_if #(.N(5)) sif ();
    assign sif.raw = {thermal_foldback_enable_pin, temp_warn_raw, temp_err_raw,
                      overcurrent_raw, undervoltage_raw};
    ptp_sync #(.N(5)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .bus(sif.sync)
    );
    logic fb_en, warn, terr, oc, uv;
    assign {fb_en, warn, terr, oc, uv} = sif.clean;

    // Foldback machine.
    typedef enum logic [3:0] {
        PTP_FB_IDLE = 4'b0001,
        PTP_FB_ATTACK = 4'b0010,
        PTP_FB_QUAL = 4'b0100,
        PTP_FB_RELEASE = 4'b1000
    } ptp_fb_e;
    ptp_fb_e fb, next_fb;
    logic [31:0] fb_cnt, next_fb_cnt;
    logic [AW-1:0] atten, next_atten;
    logic warn_d, next_warn_d, cool, next_cool;
    logic warn_rise, expire;
    assign warn_rise = warn && !warn_d;
    assign expire = (fb_cnt == 32'(ATTACK_CYC - 1));

    always_comb begin
        next_fb = fb;
        next_fb_cnt = fb_cnt + 32'h1;
        next_atten = atten;
        next_warn_d = warn;
        next_cool = cool && !warn;
        if (!fb_en) begin
            next_fb = PTP_FB_IDLE;
            next_fb_cnt = '0;
            next_atten = ATTEN_RESET_V;
        end else begin
            case (fb)
                PTP_FB_IDLE: begin
                    next_fb_cnt = '0;
                    if (warn) begin
                        next_fb = PTP_FB_ATTACK;
                    end
                end
                PTP_FB_ATTACK: begin
                    if (expire) begin
                        next_fb_cnt = '0;
                        if (warn) begin
                            if (atten != AMAX) begin
                                next_atten = atten + 1'b1;
                            end
                        end else begin
                            next_fb = PTP_FB_QUAL;
                            next_cool = 1'b1;
                        end
                    end
                end
                PTP_FB_QUAL: begin
                    if (warn_rise) begin
                        next_fb = PTP_FB_ATTACK;
                        next_fb_cnt = '0;
                    end else if (expire) begin
                        next_fb_cnt = '0;
                        next_fb = (cool && !warn) ? PTP_FB_RELEASE : PTP_FB_ATTACK;
                    end
                end
                PTP_FB_RELEASE: begin
                    if (warn_rise) begin
                        next_fb = PTP_FB_ATTACK;
                        next_fb_cnt = '0;
                    end else if (atten == '0) begin
                        next_fb = PTP_FB_IDLE;
                    end else if (expire) begin
                        next_fb_cnt = '0;
                        if (atten > AW'(RELEASE_STEP)) begin
                            next_atten = atten - AW'(RELEASE_STEP);
                        end else begin
                            next_atten = '0;
                        end
                    end
                end
                default: begin
                    next_fb = PTP_FB_IDLE;
                    next_fb_cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fb <= PTP_FB_IDLE;
            fb_cnt <= '0;
            atten <= ptp_pkg::ATTEN_RESET;
            warn_d <= 1'b0;
            cool <= 1'b0;
        end else if (clk_en) begin
            fb <= next_fb;
            fb_cnt <= next_fb_cnt;
            atten <= next_atten;
            warn_d <= next_warn_d;
            cool <= next_cool;
        end
    end

    // Shutdown machine.
    typedef enum logic [3:0] {
        PTP_SD_RUN = 4'b0001,
        PTP_SD_WAIT = 4'b0010,
        PTP_SD_PROBE = 4'b0100,
        PTP_SD_OFF = 4'b1000
    } ptp_sd_e;
    ptp_sd_e sd, next_sd;
    logic [31:0] sd_cnt, next_sd_cnt;
    logic [2:0] tries, next_tries;

    always_comb begin
        next_sd = sd;
        next_sd_cnt = sd_cnt + 32'h1;
        next_tries = tries;
        if (terr || uv) begin
            next_sd = PTP_SD_OFF;
        end else begin
            case (sd)
                PTP_SD_RUN: begin
                    next_sd_cnt = '0;
                    if (oc) begin
                        next_sd = PTP_SD_WAIT;
                        next_tries = 3'h1;
                    end
                end
                PTP_SD_WAIT: begin
                    if (sd_cnt == 32'(RETRY_CYC - 1)) begin
                        next_sd = PTP_SD_PROBE;
                        next_sd_cnt = '0;
                    end
                end
                PTP_SD_PROBE: begin
                    if (oc) begin
                        next_sd_cnt = '0;
                        if (tries == 3'(ptp_pkg::RETRY_MAX)) begin
                            next_sd = PTP_SD_OFF;
                        end else begin
                            next_sd = PTP_SD_WAIT;
                            next_tries = tries + 3'h1;
                        end
                    end else if (sd_cnt == 32'(OC_WIN_CYC - 1)) begin
                        next_sd = PTP_SD_RUN;
                        next_tries = '0;
                    end
                end
                PTP_SD_OFF: begin
                    next_sd_cnt = '0;
                end
                default: begin
                    next_sd = PTP_SD_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sd <= PTP_SD_RUN;
            sd_cnt <= '0;
            tries <= '0;
        end else if (clk_en) begin
            sd <= next_sd;
            sd_cnt <= next_sd_cnt;
            tries <= next_tries;
        end
    end

    logic pen, next_pen;
    assign next_pen = (next_sd == PTP_SD_RUN) || (next_sd == PTP_SD_PROBE);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pen <= 1'b1;
        end else if (clk_en) begin
            pen <= next_pen;
        end
    end

    assign atten_steps = atten;
    assign power_out_en = pen;
    assign shutdown = (sd == PTP_SD_OFF);
    assign thermal_warning_out_o = 1'b0;
    assign overcurrent_error_out_o = 1'b0;
    assign undervoltage_thermal_error_out_o = 1'b0;
    assign thermal_warning_out_oe = warn || terr;
    assign overcurrent_error_out_oe = oc;
    assign undervoltage_thermal_error_out_oe = uv || terr;

    a_hot_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && fb_en && fb == PTP_FB_ATTACK && expire && warn && atten != AMAX
        |=> atten == $past(atten) + 1'b1) else $error("attenuation did not step");
    a_cool_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && fb_en && fb == PTP_FB_ATTACK && expire && !warn
        |=> fb == PTP_FB_QUAL && $stable(atten)) else $error("cool expiry wrong");
    a_rise_attack: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && fb_en && (fb == PTP_FB_QUAL || fb == PTP_FB_RELEASE) && warn_rise
        |=> fb == PTP_FB_ATTACK) else $error("crossing did not restart");
    a_fb_disabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && !fb_en |=> atten == '0) else $error("attenuation while disabled");
    a_hard_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && (terr || uv) |=> shutdown && !power_out_en) else $error("no shutdown");
    a_oc_tristate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && sd == PTP_SD_RUN && oc && !terr && !uv |=> !power_out_en)
        else $error("over-current did not tri-state");
    a_fifth_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && sd == PTP_SD_PROBE && oc && tries == 3'(ptp_pkg::RETRY_MAX)
        |=> shutdown) else $error("no shutdown after fifth attempt");
    a_off_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
        shutdown |=> shutdown && !power_out_en) else $error("left shutdown");
    a_release_dn: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fb == PTP_FB_RELEASE |=> atten <= $past(atten)) else $error("release raised");
endmodule : ptp_protect

// file: core/ptp_sync.sv
`timescale 1ns/1ps
module ptp_sync #(
    parameter int N = 5
) (
    input wire logic clk_sys, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic clk_en, // Clock enable.
    ptp_sync_if.sync bus // Raw pins in, filtered levels out.
);
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] held;
    logic [N-1:0] next_held;

    // A change counts once the second and third stage agree.
    always_comb begin
        next_held = held;
        for (int i = 0; i < N; i++) begin
            if (s2[i] == s3[i]) begin
                next_held[i] = s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            held <= '0;
        end else if (clk_en) begin
            s1 <= bus.raw;
            s2 <= s1;
            s3 <= s2;
            held <= next_held;
        end
    end

    assign bus.clean = held;
endmodule : ptp_sync

// file: testbench/power_stage_thermal_protection_tb_top.sv
`timescale 1ns/1ps
module power_stage_thermal_protection_tb_top;
    localparam int AC = 20;
    localparam int RC = 30;
    localparam int WC = 12;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b0;
    logic hot = 1'b0;
    logic overheat = 1'b0;
    logic short_load = 1'b0;
    logic supply_low = 1'b0;
    logic warn, terr, oc, uv, pwr, sd, wo, we, oo, oe, uo, ue;
    logic [ptp_pkg::ATTEN_W-1:0] att;
    int fails = 0;
    int num_checks = 0;
    always #20 clk_sys = ~clk_sys;
    ptp_sensor_model ptp_sensor_model_i (.clk_sys(clk_sys), .hot(hot), .overheat(overheat),
        .short_load(short_load), .supply_low(supply_low), .power_out_en(pwr),
        .temp_warn_raw(warn), .temp_err_raw(terr), .overcurrent_raw(oc),
        .undervoltage_raw(uv));
    ptp_protect #(.ATTACK_CYC(AC), .RETRY_CYC(RC), .OC_WIN_CYC(WC), .RELEASE_STEP(1))
        ptp_protect_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
        .thermal_foldback_enable_pin(en), .temp_warn_raw(warn), .temp_err_raw(terr),
        .overcurrent_raw(oc), .undervoltage_raw(uv), .atten_steps(att),
        .power_out_en(pwr), .shutdown(sd), .thermal_warning_out_o(wo),
        .thermal_warning_out_oe(we), .overcurrent_error_out_o(oo),
        .overcurrent_error_out_oe(oe), .undervoltage_thermal_error_out_o(uo),
        .undervoltage_thermal_error_out_oe(ue));
    task automatic tick(input int n);
        // Returns on the rising edge; outputs read here still show their settled values.
        repeat (n) begin
            @(posedge clk_sys);
        end
    endtask : tick
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Waits until the attenuation leaves a value, at most lim cycles.
    task automatic wait_att(input logic [7:0] old, input int lim);
        int n;
        n = 0;
        while (att === old && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_att
    task automatic do_reset;
        rst_n <= 1'b0;
        tick(4);
        rst_n <= 1'b1;
        tick(6);
        check({pwr, sd, wo, we, oo, oe, uo, ue}, 8'h80);
        check(att, 8'h00);
    endtask : do_reset
    task automatic t_foldback;
        en <= 1'b1;
        hot <= 1'b1;
        tick(AC);
        check(att, 8'h00);
        check(we, 1'b1);
        for (int k = 1; k <= 3; k++) begin
            wait_att(k - 1, 12);
            check(att, k);
            tick(AC - 3);
            check(att, k);
        end
        // The die is still hot at the next expiry, so a fourth step lands first.
        wait_att(8'h03, 6);
        hot <= 1'b0;
        tick(AC);
        check(att, 8'h04);
        wait_att(8'h04, 2 * AC + 12);
        check(att, 8'h03);
        hot <= 1'b1;
        wait_att(8'h03, AC + 12);
        check(att, 8'h04);
        hot <= 1'b0;
        // The first release needs the rest of the attack period, a check and a period.
        for (int v = 3; v >= 0; v--) begin
            wait_att(8'(v + 1), 3 * AC + 12);
            check(att, 8'(v));
        end
        tick(3 * AC);
        check(att, 8'h00);
        $display("test foldback done");
    endtask : t_foldback
    task automatic t_disabled;
        en <= 1'b0;
        hot <= 1'b1;
        tick(4 * AC);
        check(att, 8'h00);
        check({we, pwr}, 8'h03);
        hot <= 1'b0;
        tick(8);
        $display("test disabled done");
    endtask : t_disabled
    task automatic t_oc_single;
        for (int k = 0; k < 6; k++) begin
            short_load <= 1'b1;
            tick(8);
            check({pwr, oe}, 8'h01);
            short_load <= 1'b0;
            tick(RC + 8);
            check(pwr, 1'b1);
            tick(WC + 8);
            check({pwr, sd}, 8'h02);
        end
        $display("test oc single done");
    endtask : t_oc_single
    task automatic t_oc_retry;
        int ups;
        int n;
        logic last;
        ups = 0;
        n = 0;
        last = 1'b0;
        short_load <= 1'b1;
        tick(8);
        check(pwr, 1'b0);
        while (sd !== 1'b1 && n < 8 * (RC + WC + 20)) begin
            tick(1);
            if (pwr === 1'b1 && last === 1'b0) ups++;
            last = pwr;
            n++;
        end
        check(ups, ptp_pkg::RETRY_MAX);
        check({sd, pwr}, 8'h02);
        short_load <= 1'b0;
        tick(RC + WC + 20);
        check({sd, pwr}, 8'h02);
        do_reset();
        $display("test oc retry done");
    endtask : t_oc_retry
    task automatic t_hard_faults;
        for (int k = 0; k < 2; k++) begin
            supply_low <= (k == 0);
            overheat <= (k == 1);
            tick(8);
            check({sd, pwr, ue}, 8'h05);
            check(we, 8'(k));
            supply_low <= 1'b0;
            overheat <= 1'b0;
            tick(RC + WC + 20);
            check({sd, pwr}, 8'h02);
            do_reset();
        end
        $display("test hard faults done");
    endtask : t_hard_faults
    task automatic summarize;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        #(40 * 20000);
        fails++;
        summarize();
    end
    initial begin
        do_reset();
        t_foldback();
        t_disabled();
        t_oc_single();
        t_oc_retry();
        t_hard_faults();
        summarize();
    end
endmodule : power_stage_thermal_protection_tb_top

// file: testbench/ptp_sensor_model.sv
`timescale 1ns/1ps
module ptp_sensor_model (
    input wire logic clk_sys, // System clock.
    input wire logic hot, // Die above warning level.
    input wire logic overheat, // Die above error level.
    input wire logic short_load, // Load shorted.
    input wire logic supply_low, // Stage supply low.
    input wire logic power_out_en, // Stages driving.
    output logic temp_warn_raw = 1'b0, // Warning sensor.
    output logic temp_err_raw = 1'b0, // Error sensor.
    output logic overcurrent_raw = 1'b0, // Current sensor.
    output logic undervoltage_raw = 1'b0 // Supply monitor.
);
    // A shorted load draws excess current only while the stages drive it.
    always @(posedge clk_sys) begin
        temp_warn_raw <= hot | overheat;
        temp_err_raw <= overheat;
        overcurrent_raw <= short_load & power_out_en;
        undervoltage_raw <= supply_low;
    end
endmodule : ptp_sensor_model
